// ---- tsr_defs.svh ----
// constants for the time-slot router: register offsets, fields, reset values, rates
// assumes inclusion by bare name from the router and walker modules
// Functional notes
// - each channel: dedicated pins or multiplexed link
// - any channel mix onto one or two links
// - static frames: disable channels before rerouting
// - dynamic frames: reroute with channels attached
// - global mode: link enables, static/dynamic select
// - serial mode: mgmt clocks, sync/async, mgmt pins
// - clock route: comm clocks and dedicated pins
// - two links, independent transmit/receive clocks and syncs
// - four strobes, per bit or per byte
// - each slot: one transmit, one receive entry
// - routing RAM directly host readable and writable
// - routing independent of channel protocol
// - capacity 64/32/32/16 entries per direction
// - echo: receive input retransmitted on transmit
// - loopback: receive path takes transmitted signal
// - internal clock divided by 1, 4, 16, 64
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH
// register byte offsets
`define TSR_GMR_OFF 12'h000
`define TSR_SMR_OFF 12'h004
`define TSR_CRR_OFF 12'h008
`define TSR_DIV_OFF 12'h00C
`define TSR_STAT_OFF 12'h010
`define TSR_RAM_TX_PAGE 4'h1
`define TSR_RAM_RX_PAGE 4'h2
// global mode fields
`define TSR_GMR_EN0 0
`define TSR_GMR_EN1 1
`define TSR_GMR_DYN 2
`define TSR_GMR_BANK 3
// serial mode fields
`define TSR_SMR_ASYNC 2
`define TSR_SMR_ECHO 5
`define TSR_SMR_LOOP 6
// routing entry fields
`define TSR_ENT_BYTE 3
`define TSR_ENT_LAST 8
`define TSR_CHAN_NONE 3'h7
// reset values
`define TSR_GMR_RST 4'h0
`define TSR_SMR_RST 7'h00
`define TSR_CRR_RST 8'h00
`define TSR_DIV_RST 2'h0
// divider terminal counts for divide by 1, 4, 16, 64
`define TSR_DIV1_LAST 6'h00
`define TSR_DIV4_LAST 6'h03
`define TSR_DIV16_LAST 6'h0F
`define TSR_DIV64_LAST 6'h3F
`endif

// ---- tsr_pkg.sv ----
// types shared by the time-slot router and its slot walkers
// assumes the constants header supplies all numeric values
package tsr_pkg;
  // one routing RAM entry: last, strobe mask, byte mode, channel
  typedef struct packed {
    logic last;
    logic [3:0] strobe;
    logic byte_mode;
    logic [2:0] chan;
  } entry_type;
  // state of one slot walker
  typedef struct packed {
    logic clk_s1, clk_s2, clk_prev;
    logic sync_s1, sync_s2;
    logic in_frame, bit_ev, frame_start;
    logic [2:0] bitcnt;
    logic [5:0] ptr;
  } walker_state_type;
  // state of the router top
  typedef struct packed {
    logic [3:0] gmr;
    logic [6:0] smr;
    logic [7:0] crr;
    logic [1:0] div;
    logic [5:0] div_cnt;
    logic ser_en;
    logic [1:0] act_bank;
    logic [1:0] txd, txd_oe;
    logic [3:0] strobe;
    logic [5:0] ded_txd, chan_rxd, chan_rx_en, chan_tx_en;
    logic [5:0] ded_rxd_s1, ded_rxd_s2;
    logic [1:0] rxd_s1, rxd_s2;
    logic [31:0] prdata;
    logic pslverr;
  } router_state_type;
endpackage

// ---- slot_walker.sv ----
// one direction of one link: finds link clock edges and frame syncs, walks entries
// assumes clock and sync arrive from pins; ser_en is the internal serial clock enable
`timescale 1ns/1ps
`include "tsr_defs.svh"
module slot_walker #(
  parameter bit SAMPLE_RISE = 1'b1 // rising edge for receive, falling for transmit
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic ser_en,
  input wire logic enable,
  input wire logic [5:0] cap_last,
  // current entry fields
  input wire logic byte_mode,
  input wire logic last,
  // link pins
  input wire logic link_clk_pin,
  input wire logic sync_pin,
  // position outputs
  output logic [5:0] ptr,
  output logic in_frame,
  output logic bit_ev,
  output logic frame_start
);
  tsr_pkg::walker_state_type q, d;
  logic rise, fall, act;

  // edges judged only on second synchroniser stage, at internal serial rate
  assign rise = q.clk_s2 & ~q.clk_prev;
  assign fall = ~q.clk_s2 & q.clk_prev;
  assign act = ser_en & (SAMPLE_RISE ? rise : fall);

  // next state
  always_comb begin
    d = q;
    d.bit_ev = 1'b0;
    d.frame_start = 1'b0;
    d.clk_s1 = link_clk_pin;
    d.clk_s2 = q.clk_s1;
    d.sync_s1 = sync_pin;
    d.sync_s2 = q.sync_s1;
    if (ser_en) begin
      d.clk_prev = q.clk_s2;
    end
    if (!enable) begin
      // idle link walks nothing
      d.in_frame = 1'b0;
      d.ptr = 6'h00;
      d.bitcnt = 3'h0;
    end else if (act) begin
      if (q.sync_s2) begin
        // frame start: this edge carries bit 0 of entry 0
        d.frame_start = 1'b1;
        d.in_frame = 1'b1;
        d.ptr = 6'h00;
        d.bitcnt = 3'h0;
        d.bit_ev = 1'b1;
      end else if (q.in_frame) begin
        if (byte_mode && q.bitcnt != 3'h7) begin
          // per-byte entry holds for eight bits
          d.bitcnt = q.bitcnt + 3'h1;
          d.bit_ev = 1'b1;
        end else if (last || q.ptr == cap_last) begin
          // end of table: wait for next sync
          d.in_frame = 1'b0;
        end else begin
          d.ptr = q.ptr + 6'h01;
          d.bitcnt = 3'h0;
          d.bit_ev = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ptr = q.ptr;
  assign in_frame = q.in_frame;
  assign bit_ev = q.bit_ev;
  assign frame_start = q.frame_start;
endmodule

// ---- time_slot_router.sv ----
// time-slot router: six serial channels onto dedicated pins or two multiplexed links
// assumes APB master on clk; link clocks and syncs come from an external framer
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "tsr_defs.svh"
module time_slot_router (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial channel side, index 0..3 comm_channel, 4..5 mgmt_channel
  input wire logic [5:0] chan_txd,
  input wire logic [5:0] chan_enabled,
  output logic [5:0] chan_tx_en,
  output logic [5:0] chan_rxd,
  output logic [5:0] chan_rx_en,
  // dedicated pins per channel
  input wire logic [5:0] ded_rxd,
  output logic [5:0] ded_txd,
  // multiplexed link pins, index per link
  input wire logic [1:0] link_tx_clk,
  input wire logic [1:0] link_tx_sync,
  input wire logic [1:0] link_rx_clk,
  input wire logic [1:0] link_rx_sync,
  input wire logic [1:0] link_rxd,
  output logic [1:0] link_txd,
  output logic [1:0] link_txd_oe,
  // strobes for off-chip devices
  output logic [3:0] strobe
);
  tsr_pkg::router_state_type q, d;

  // routing RAM, one table per direction
  tsr_pkg::entry_type ram_tx [0:63];
  tsr_pkg::entry_type ram_rx [0:63];

  // walker signals, index w = link*2 + dir, dir 0 transmit, 1 receive
  logic [5:0] w_ptr [0:3];
  logic [3:0] w_in_frame, w_bit_ev, w_frame_start;
  logic [3:0] w_clk_pin, w_sync_pin;
  logic [5:0] w_idx [0:3];
  tsr_pkg::entry_type w_ent [0:3];

  // decoded configuration
  logic two_links, dyn, locked;
  logic [6:0] cap;
  logic [5:0] cap_last;
  logic [5:0] clk_route, dedicated;
  logic [1:0] link_en;

  // bus decode
  logic setup, access, wr_ok;
  logic ram_tx_hit, ram_rx_hit, reg_hit;

  assign link_en = {q.gmr[`TSR_GMR_EN1], q.gmr[`TSR_GMR_EN0]};
  assign dyn = q.gmr[`TSR_GMR_DYN];
  assign two_links = q.gmr[`TSR_GMR_EN1];
  // per-direction depth halves for dynamic banks and for a second link
  assign cap = 7'h40 >> ({1'b0, two_links} + {1'b0, dyn});
  assign cap_last = 6'(cap - 7'h01);
  // mgmt clocks and pins from serial mode, comm from clock route
  assign clk_route = {q.smr[1:0], q.crr[3:0]};
  assign dedicated = {q.smr[4:3], q.crr[7:4]};

  // static frames refuse routing changes while an attached channel runs
  assign locked = ~dyn & (|link_en) & (|(chan_enabled & ~dedicated));

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign ram_tx_hit = paddr[11:8] == `TSR_RAM_TX_PAGE;
  assign ram_rx_hit = paddr[11:8] == `TSR_RAM_RX_PAGE;
  assign reg_hit = paddr == `TSR_GMR_OFF || paddr == `TSR_SMR_OFF ||
                   paddr == `TSR_CRR_OFF || paddr == `TSR_DIV_OFF ||
                   paddr == `TSR_STAT_OFF;
  // write commits at access edge only when the setup check found no error
  assign wr_ok = access & pwrite & ~q.pslverr;

  // walker pin selection: synchronous mode shares transmit clock and sync
  always_comb begin
    for (int l = 0; l < 2; l++) begin
      w_clk_pin[2*l] = link_tx_clk[l];
      w_sync_pin[2*l] = link_tx_sync[l];
      // independent receive timing only in asynchronous mode
      w_clk_pin[2*l+1] = q.smr[`TSR_SMR_ASYNC] ? link_rx_clk[l] : link_tx_clk[l];
      w_sync_pin[2*l+1] = q.smr[`TSR_SMR_ASYNC] ? link_rx_sync[l] : link_tx_sync[l];
    end
  end

  // one walker per link and direction
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : walkers
      // entry address: link base, then bank, then slot pointer
      assign w_idx[g] = 6'((g / 2) * (two_links ? 32 : 0)) +
                        ((dyn && q.act_bank[g / 2]) ? cap_last + 6'h01 : 6'h00) +
                        w_ptr[g];
      // each slot has a transmit entry and a receive entry
      assign w_ent[g] = (g % 2 == 0) ? ram_tx[w_idx[g]] : ram_rx[w_idx[g]];
      slot_walker #(
        .SAMPLE_RISE((g % 2) == 1)
      ) walker (
        .clk(clk),
        .rst(rst),
        .ser_en(q.ser_en),
        .enable(link_en[g / 2]),
        .cap_last(cap_last),
        .byte_mode(w_ent[g].byte_mode),
        .last(w_ent[g].last),
        .link_clk_pin(w_clk_pin[g]),
        .sync_pin(w_sync_pin[g]),
        .ptr(w_ptr[g]),
        .in_frame(w_in_frame[g]),
        .bit_ev(w_bit_ev[g]),
        .frame_start(w_frame_start[g])
      );
    end
  endgenerate

  // routing RAM: host writes; no reset, contents undefined until filled
  always_ff @(posedge clk) begin
    if (wr_ok && ram_tx_hit) begin
      ram_tx[paddr[7:2]] <= pwdata[8:0];
    end
    if (wr_ok && ram_rx_hit) begin
      ram_rx[paddr[7:2]] <= pwdata[8:0];
    end
  end

  // next state for registers, divider, routing and bus answers
  always_comb begin
    d = q;
    d.chan_tx_en = 6'h00;
    d.chan_rx_en = 6'h00;
    // pin synchronisers, first stage read only by second
    d.ded_rxd_s1 = ded_rxd;
    d.ded_rxd_s2 = q.ded_rxd_s1;
    d.rxd_s1 = link_rxd;
    d.rxd_s2 = q.rxd_s1;

    // internal serial clock enable, divide by 1, 4, 16 or 64
    d.ser_en = 1'b0;
    unique case (q.div)
      2'h0: d.ser_en = q.div_cnt == `TSR_DIV1_LAST;
      2'h1: d.ser_en = q.div_cnt == `TSR_DIV4_LAST;
      2'h2: d.ser_en = q.div_cnt == `TSR_DIV16_LAST;
      2'h3: d.ser_en = q.div_cnt == `TSR_DIV64_LAST;
    endcase
    d.div_cnt = d.ser_en ? 6'h00 : q.div_cnt + 6'h01;

    // dynamic frames: shadow bank taken over at each link's frame start
    for (int l = 0; l < 2; l++) begin
      if (w_frame_start[2*l]) begin
        d.act_bank[l] = q.gmr[`TSR_GMR_BANK];
      end
    end

    // dedicated pins: channel runs on internal clock through own pins
    for (int i = 0; i < 6; i++) begin
      if (q.ser_en && dedicated[i] && clk_route[i]) begin
        d.ded_txd[i] = chan_txd[i];
        d.chan_tx_en[i] = 1'b1;
        d.chan_rxd[i] = q.ded_rxd_s2[i];
        d.chan_rx_en[i] = 1'b1;
      end
    end

    // link routing, protocol blind: only bits and enables move
    for (int l = 0; l < 2; l++) begin
      if (!link_en[l]) begin
        // disabled link is silent
        d.txd_oe[l] = 1'b0;
      end else if (q.smr[`TSR_SMR_ECHO]) begin
        // echo returns the received level three clocks after the pin, every cycle
        d.txd[l] = q.rxd_s2[l];
        d.txd_oe[l] = 1'b1;
      end else if (w_bit_ev[2*l]) begin
        d.txd_oe[l] = 1'b0;
        if (w_ent[2*l].chan != `TSR_CHAN_NONE && w_ent[2*l].chan < 3'h6) begin
          // attached, clocked channel supplies this bit
          if (!dedicated[w_ent[2*l].chan] && clk_route[w_ent[2*l].chan]) begin
            d.txd[l] = chan_txd[w_ent[2*l].chan];
            d.txd_oe[l] = 1'b1;
            d.chan_tx_en[w_ent[2*l].chan] = 1'b1;
          end
        end
      end else if (!w_in_frame[2*l]) begin
        d.txd_oe[l] = 1'b0;
      end
      if (link_en[l] && w_bit_ev[2*l+1] && w_ent[2*l+1].chan < 3'h6) begin
        if (!dedicated[w_ent[2*l+1].chan] && clk_route[w_ent[2*l+1].chan]) begin
          // loopback takes the transmitted level instead of the pin
          d.chan_rxd[w_ent[2*l+1].chan] =
            q.smr[`TSR_SMR_LOOP] ? q.txd[l] : q.rxd_s2[l];
          d.chan_rx_en[w_ent[2*l+1].chan] = 1'b1;
        end
      end
    end

    // strobes follow the transmit entry for the whole bit or byte
    d.strobe = 4'h0;
    for (int l = 0; l < 2; l++) begin
      if (link_en[l] && w_in_frame[2*l]) begin
        d.strobe = d.strobe | w_ent[2*l].strobe;
      end
    end

    // setup phase: fix error and read data for the access phase
    if (setup) begin
      d.pslverr = ~(reg_hit | ram_tx_hit | ram_rx_hit);
      d.prdata = 32'h0000_0000;
      if (pwrite && locked && (ram_tx_hit || ram_rx_hit ||
          paddr == `TSR_SMR_OFF || paddr == `TSR_CRR_OFF)) begin
        d.pslverr = 1'b1;
      end
      if (pwrite && paddr == `TSR_STAT_OFF) begin
        d.pslverr = 1'b1; // status is read only
      end
      if (!pwrite) begin
        if (ram_tx_hit) begin
          d.prdata = {23'h0, ram_tx[paddr[7:2]]};
        end else if (ram_rx_hit) begin
          d.prdata = {23'h0, ram_rx[paddr[7:2]]};
        end else begin
          unique case (paddr)
            `TSR_GMR_OFF: d.prdata = {28'h0, q.gmr};
            `TSR_SMR_OFF: d.prdata = {25'h0, q.smr};
            `TSR_CRR_OFF: d.prdata = {24'h0, q.crr};
            `TSR_DIV_OFF: d.prdata = {30'h0, q.div};
            `TSR_STAT_OFF: d.prdata = {20'h0, w_ptr[0], q.act_bank, w_in_frame};
            default: d.prdata = 32'h0000_0000;
          endcase
        end
      end
    end

    // register writes at the access edge
    if (wr_ok) begin
      unique case (paddr)
        `TSR_GMR_OFF: d.gmr = pwdata[3:0];
        `TSR_SMR_OFF: d.smr = pwdata[6:0];
        `TSR_CRR_OFF: d.crr = pwdata[7:0];
        `TSR_DIV_OFF: d.div = pwdata[1:0];
        default: d.div = q.div;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.gmr <= `TSR_GMR_RST;
      q.smr <= `TSR_SMR_RST;
      q.crr <= `TSR_CRR_RST;
      q.div <= `TSR_DIV_RST;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign pready = 1'b1;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign chan_tx_en = q.chan_tx_en;
  assign chan_rxd = q.chan_rxd;
  assign chan_rx_en = q.chan_rx_en;
  assign ded_txd = q.ded_txd;
  assign link_txd = q.txd;
  assign link_txd_oe = q.txd_oe;
  assign strobe = q.strobe;
endmodule

// ---- tsr_chk.sv ----
// assertions on the router's bus, strobe and link drive ports
// assumes binding onto the router top; shadows accepted register writes
`timescale 1ns/1ps
`include "tsr_defs.svh"
module tsr_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // channel and link side
  input wire logic [5:0] chan_enabled,
  input wire logic [1:0] link_txd_oe,
  input wire logic [3:0] strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] gmr_q; // shadow link enables and dynamic bit
  logic [5:0] ded_q; // shadow dedicated selects
  logic [1:0] en_d1_q, en_d2_q; // enables delayed, to allow drain
  logic setup_q; // previous cycle was a setup cycle
  logic wr_ok, lock, cfg_addr;
  logic [1:0] en_any;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign cfg_addr = paddr == `TSR_SMR_OFF || paddr == `TSR_CRR_OFF || paddr[11:8] inside {4'h1, 4'h2};
  // static frames with an attached, non-dedicated channel lock routing
  assign lock = !gmr_q[2] && gmr_q[1:0] != 2'h0 && (chan_enabled & ~ded_q) != 6'h00;
  // a link may still drain two cycles after it is switched off
  assign en_any = gmr_q[1:0] | en_d1_q | en_d2_q;
  // shadow follows accepted writes only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gmr_q <= 3'h0;
      ded_q <= 6'h00;
      en_d1_q <= 2'h0;
      en_d2_q <= 2'h0;
      setup_q <= 1'b0;
    end else begin
      setup_q <= psel && !penable;
      en_d1_q <= gmr_q[1:0];
      en_d2_q <= en_d1_q;
      if (wr_ok && paddr == `TSR_GMR_OFF) begin
        gmr_q <= pwdata[2:0];
      end
      if (wr_ok && paddr == `TSR_SMR_OFF) begin
        ded_q[5:4] <= pwdata[4:3];
      end
      if (wr_ok && paddr == `TSR_CRR_OFF) begin
        ded_q[3:0] <= pwdata[7:4];
      end
    end
  end
  property p_ready;
    psel |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in a transfer");
  property p_unmapped;
    psel && penable && paddr[11:8] > 4'h2 |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_status_ro;
    psel && penable && pwrite && paddr == `TSR_STAT_OFF |-> pslverr;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write accepted");
  property p_gmr_open;
    psel && penable && paddr == `TSR_GMR_OFF |-> !pslverr;
  endproperty
  a_gmr_open: assert property (p_gmr_open) else $error("global mode refused");
  property p_lock;
    psel && penable && pwrite && lock && cfg_addr |-> pslverr;
  endproperty
  a_lock: assert property (p_lock) else $error("locked routing write accepted");
  property p_dyn_open;
    psel && penable && gmr_q[2] && cfg_addr |-> !pslverr;
  endproperty
  a_dyn_open: assert property (p_dyn_open) else $error("dynamic write refused");
  property p_oe_off;
    (link_txd_oe & ~en_any) == 2'h0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("disabled link driven");
  property p_strobe_off;
    en_any == 2'h0 |-> strobe == 4'h0;
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("strobe with links off");
  property p_hold;
    !setup_q |-> $stable(prdata) && $stable(pslverr);
  endproperty
  a_hold: assert property (p_hold) else $error("read answer changed");
endmodule
bind time_slot_router tsr_chk i_tsr_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chan_enabled(chan_enabled), .link_txd_oe(link_txd_oe),
  .strobe(strobe)
);

// ---- framer_model.sv ----
// behavioural framer: bit clock, frame sync and receive data of one link
// assumes go rises once per frame; the clock stands low between frames
`timescale 1ns/1ps
module framer_model #(
  parameter int BITS = 4 // clock periods per frame
) (
  // frame request and receive value
  input wire logic go,
  input wire logic rx_bit,
  // link pins
  output logic lclk,
  output logic lsync,
  output logic lrxd
);
  // receive line always driven
  assign lrxd = rx_bit;
  // sync moves mid-low so both edges of the first bit see it high
  initial begin
    lclk = 1'b0;
    lsync = 1'b0;
    #37;
    forever begin
      @(posedge go);
      for (int i = 0; i < BITS; i++) begin
        #200 lsync = (i == 0);
        #200 lclk = 1'b1;
        #400 lclk = 1'b0;
      end
    end
  end
endmodule

// ---- tb_time_slot_router.sv ----
// self-checking bench for the time-slot router
// assumes the bound checker and one framer model per link
`timescale 1ns/1ps
`include "tsr_defs.svh"
module tb_time_slot_router;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rerr, counting;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [5:0] chan_txd, chan_enabled, chan_tx_en, chan_rxd, chan_rx_en, ded_rxd, ded_txd;
  logic [1:0] lclk, lsync, lrxd, rxb, go, link_txd, link_txd_oe;
  logic [3:0] strobe;
  logic [3:0] seen_stb = 4'h0; // strobes seen during a frame
  int bad_count = 0;
  int samples_checked = 0;
  int cnt0 = 0;
  int cnt1 = 0;
  int cnt2 = 0;
  logic dchk = 1'b0; // dedicated-pin checks on
  logic tx_h; // channel 0 transmit bit, one edge old
  logic [2:0] rx_h; // channel 0 dedicated pin bits, newest in bit 0
  // receive uses the transmit pins in sync mode
  time_slot_router i_time_slot_router (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_txd(chan_txd), .chan_enabled(chan_enabled),
    .chan_tx_en(chan_tx_en), .chan_rxd(chan_rxd), .chan_rx_en(chan_rx_en),
    .ded_rxd(ded_rxd), .ded_txd(ded_txd), .link_tx_clk(lclk), .link_tx_sync(lsync),
    .link_rx_clk(lclk), .link_rx_sync(lsync), .link_rxd(lrxd), .link_txd(link_txd),
    .link_txd_oe(link_txd_oe), .strobe(strobe)
  );
  framer_model i_framer_model_0 (
    .go(go[0]), .rx_bit(rxb[0]), .lclk(lclk[0]), .lsync(lsync[0]), .lrxd(lrxd[0])
  );
  framer_model i_framer_model_1 (
    .go(go[1]), .rx_bit(rxb[1]), .lclk(lclk[1]), .lsync(lsync[1]), .lrxd(lrxd[1])
  );
  // 100 ns system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // random channel data, slot counters
  always @(posedge clk) begin
    chan_txd <= 6'($urandom);
    ded_rxd <= 6'($urandom);
    tx_h <= chan_txd[0];
    rx_h <= {rx_h[1:0], ded_rxd[0]};
    // dedicated path: transmit one edge late, receive through two syncs and a register
    if (dchk) begin
      chk("dedicated tx", {31'h0, ded_txd[0]}, {31'h0, tx_h});
      chk("dedicated rx", {31'h0, chan_rxd[0]}, {31'h0, rx_h[2]});
      chk("dedicated enables", {30'h0, chan_rx_en[0], chan_tx_en[0]}, 32'h3);
    end
    if (counting) begin
      cnt0 <= cnt0 + int'(chan_tx_en[0]);
      cnt1 <= cnt1 + int'(chan_tx_en[1]);
      cnt2 <= cnt2 + int'(chan_rx_en[2]);
      seen_stb <= seen_stb | strobe;
    end
  end
  // bits a transmit entry gives a channel
  function automatic int bits_of(logic [8:0] e, int ch);
    return (e[2:0] == 3'(ch)) ? (e[`TSR_ENT_BYTE] ? 8 : 1) : 0;
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask
  // one bus transfer; waits for pready, takes the answer at that edge
  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles of the run
  initial begin
    #500000;
    bad_count++;
    print_verdict();
  end
  initial begin
    logic [11:0] a;
    logic [31:0] v;
    {psel, penable, pwrite, counting, paddr, pwdata, chan_enabled, rxb, go} = '0;
    {chan_txd, ded_rxd} = '0;
    rst = 1'b1;
    void'($urandom(55));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values of mode, route and divider registers
    for (int i = 0; i < 4; i++) begin
      rw(1'b0, 12'(4 * i), 32'h0);
      chk("reset value", rdat, 32'h0);
    end
    // divide by 1 is left last: the 800 ns link clock needs a fast internal clock
    for (int c = 3; c >= 0; c--) begin
      rw(1'b1, `TSR_DIV_OFF, 32'(c));
      rw(1'b0, `TSR_DIV_OFF, 32'h0);
      chk("divider", rdat, 32'(c));
    end
    // random entries of both pages, read back at entry width
    for (int i = 0; i < 16; i++) begin
      a = {(i[0] ? `TSR_RAM_RX_PAGE : `TSR_RAM_TX_PAGE), 6'($urandom), 2'h0};
      v = $urandom;
      rw(1'b1, a, v);
      rw(1'b0, a, 32'h0);
      chk("routing entry", rdat, v & 32'h1FF);
    end
    rw(1'b0, 12'h300, 32'h0);
    chk("unmapped error", 32'(rerr), 32'h1);
    rw(1'b1, `TSR_STAT_OFF, 32'h0);
    chk("status write error", 32'(rerr), 32'h1);
    // table filled before links go on: two slots on link 0, one on link 1
    rw(1'b1, 12'h100, 32'h010);
    rw(1'b1, 12'h104, 32'h100);
    rw(1'b1, 12'h180, 32'h121);
    rw(1'b1, 12'h200, 32'h107);
    rw(1'b1, 12'h280, 32'h107);
    rw(1'b1, `TSR_CRR_OFF, 32'h03);
    rw(1'b1, `TSR_GMR_OFF, 32'h3);
    counting <= 1'b1;
    go <= 2'h3;
    repeat (60) @(posedge clk);
    counting <= 1'b0;
    go <= 2'h0;
    chk("link0 bits", cnt0, bits_of(9'h010, 0) + bits_of(9'h100, 0));
    chk("link1 bits", cnt1, bits_of(9'h121, 1));
    chk("strobes", {28'h0, seen_stb}, 32'h3);
    // static frames: an attached channel locks the routing
    chan_enabled <= 6'h01;
    rw(1'b1, `TSR_SMR_OFF, 32'h20);
    chk("locked error", 32'(rerr), 32'h1);
    rw(1'b0, `TSR_SMR_OFF, 32'h0);
    chk("locked no effect", rdat, 32'h0);
    // dynamic frames take the same write, which turns echo on
    rw(1'b1, `TSR_GMR_OFF, 32'h7);
    rw(1'b1, `TSR_SMR_OFF, 32'h20);
    chk("dynamic error", 32'(rerr), 32'h0);
    for (int b = 0; b < 2; b++) begin
      rxb <= {2{1'(b)}};
      repeat (10) @(posedge clk);
      chk("echo", {30'h0, link_txd}, {30'h0, {2{1'(b)}}});
    end
    rw(1'b1, `TSR_GMR_OFF, 32'h0);
    chan_enabled <= 6'h00;
    repeat (4) @(posedge clk);
    chk("idle strobes", {28'h0, strobe}, 32'h0);
    chk("idle drive", {30'h0, link_txd_oe}, 32'h0);
    // channel 0 on its own pins, clocked at the internal rate
    rw(1'b1, `TSR_CRR_OFF, 32'h11);
    repeat (4) @(posedge clk);
    dchk <= 1'b1;
    repeat (20) @(posedge clk);
    dchk <= 1'b0;
    // loopback: pin held low, last transmitted level still high from the echo run
    rxb <= 2'h0;
    rw(1'b1, `TSR_CRR_OFF, 32'h04);
    rw(1'b1, `TSR_SMR_OFF, 32'h40);
    rw(1'b1, 12'h200, 32'h102);
    rw(1'b1, `TSR_GMR_OFF, 32'h1);
    counting <= 1'b1;
    go <= 2'h1;
    repeat (60) @(posedge clk);
    counting <= 1'b0;
    chk("loopback bits", cnt2, 1);
    chk("loopback level", {31'h0, chan_rxd[2]}, 32'h1);
    print_verdict();
  end
endmodule
